//--- rtl/ccdh_defines.svh
`ifndef CCDH_DEFINES_SVH
`define CCDH_DEFINES_SVH

// Edge grid
`define CCDH_POSITIONS 48
`define CCDH_QUAD_SIZE 12
`define CCDH_CODE_W 6
`define CCDH_POS_W 6
`define CCDH_LAST_POS 6'h2f
`define CCDH_FIRST_POS 6'h00
`define CCDH_QUAD_LSB 4
`define CCDH_OFFS_MAX 4'hb

// Drive code widths
`define CCDH_HDRV_W 4
`define CCDH_RGDRV_W 3
`define CCDH_HLDRV_W 3

// Blanking windows
`define CCDH_WINDOWS 3
`define CCDH_WIN_IDX_W 2
`define CCDH_WIN_DONE 2'h3

// Edge channels: clock A, reset gate one, reset gate two
`define CCDH_CHANNELS 3
`define CCDH_CH_CLKA 0
`define CCDH_CH_RG1 1
`define CCDH_CH_RG2 2

`endif

//--- rtl/ccdh_edge_chan.sv
`timescale 1ns/1ps
`default_nettype none

`include "ccdh_defines.svh"

module ccdh_edge_chan
  import ccdh_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Grid position and settings
  input wire logic [`CCDH_POS_W-1:0] pos,
  input var ccdh_edge_cfg_s cfg,
  // Edge output after polarity
  output logic level_out
);

  typedef struct packed {
    logic level;
    logic out;
  } ccdh_chan_st_s;

  ccdh_chan_st_s st_r;
  ccdh_chan_st_s st_nxt;

  // Set at the rising code, clear at the falling code; rise wins a tie
  always_comb
  begin
    st_nxt = st_r;
    if (ccdh_code_hits(cfg.rise, pos))
      st_nxt.level = 1'b1;
    else if (ccdh_code_hits(cfg.fall, pos))
      st_nxt.level = 1'b0;
    st_nxt.out = st_nxt.level ^ cfg.pol;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level_out = st_r.out;

endmodule

`default_nettype wire

//--- rtl/ccdh_pkg.sv
`include "ccdh_defines.svh"

package ccdh_pkg;

  // Polarity and edge codes of one programmable edge channel
  typedef struct packed {
    logic pol;
    logic [`CCDH_CODE_W-1:0] rise;
    logic [`CCDH_CODE_W-1:0] fall;
  } ccdh_edge_cfg_s;

  // One blanking window, in pixels from the line start
  typedef struct packed {
    logic [11:0] start;
    logic [11:0] stop;
  } ccdh_win_s;

  // Drive strength codes held for the output drivers
  typedef struct packed {
    logic [`CCDH_HDRV_W-1:0] horiz;
    logic [`CCDH_RGDRV_W-1:0] reset_gate;
    logic [`CCDH_HLDRV_W-1:0] last_horiz;
  } ccdh_drive_s;

  // Quadrant mapping: upper two bits pick a group of 12, lower four the offset
  function automatic logic ccdh_code_hits(input logic [`CCDH_CODE_W-1:0] code,
                                          input logic [`CCDH_POS_W-1:0] pos);
    logic [`CCDH_POS_W-1:0] base;
    logic [`CCDH_POS_W-1:0] full;
    base = 6'(code[`CCDH_CODE_W-1:`CCDH_QUAD_LSB] * `CCDH_QUAD_SIZE);
    full = base + {2'h0, code[`CCDH_QUAD_LSB-1:0]};
    // Offsets 12..15 name no position and never fire
    ccdh_code_hits = (code[`CCDH_QUAD_LSB-1:0] <= `CCDH_OFFS_MAX) && (full == pos);
  endfunction

endpackage

//--- rtl/ccdh_timing_core.sv
`timescale 1ns/1ps
`default_nettype none

`include "ccdh_defines.svh"

// Notes on behaviour
// - Clock A and both reset gates are inverted when their polarity bit is 1 and passed straight when it is 0.
// - The rising edge of clock A and of each reset gate sits at the grid position its 6-bit code selects.
// - The falling edge of clock A and of each reset gate sits at the position its own 6-bit code selects.
// - The reference and data sampling strobes fire at the positions given by their own 6-bit codes.
// - A 4-bit drive code 0 to 15 is held for the four horizontal clock drivers.
// - A 3-bit drive code 0 to 7 is held for the reset gate driver.
// - A 3-bit drive code 0 to 7 is held for the last horizontal clock driver.
// - Each blanking window is given only by a start toggle and an end toggle position.
// - During blanking with the mask level high, clock A is forced high and clock B low.
// - Up to three blanking windows are supported in each line.
// - Windows are processed in order within a line, window 0 first, then 1, then 2.
// - Clock B is always the complement of clock A.
// - Each pixel period is split into 48 equal edge positions on which every edge and sample lies.
// - Edge codes map by quadrant: upper two bits pick a group of 12, lower four bits 0 to 11 the place in it.
module ccdh_timing_core
  import ccdh_pkg::*;
#(
  parameter int PIX_W = 12
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Line start, one-cycle pulse from same-clock logic
  input wire logic line_start,
  // Edge and sample settings
  input var ccdh_edge_cfg_s [`CCDH_CHANNELS-1:0] edge_cfg,
  input wire logic [`CCDH_CODE_W-1:0] ref_sample_loc,
  input wire logic [`CCDH_CODE_W-1:0] data_sample_loc,
  // Drive settings
  input var ccdh_drive_s drive_cfg,
  // Blanking settings
  input var ccdh_win_s [`CCDH_WINDOWS-1:0] blank_win,
  input wire logic blank_mask_level,
  // Sensor clocks
  output logic horiz_clock_a,
  output logic horiz_clock_b,
  output logic last_horiz_clock,
  output logic reset_gate_one,
  output logic reset_gate_two,
  // Sampling strobes
  output logic ref_level_strobe,
  output logic data_level_strobe,
  // Status and held drive codes
  output logic horiz_blanking,
  output logic [`CCDH_POS_W-1:0] edge_position,
  output var ccdh_drive_s drive_code
);

  // Pipeline: a grid position stands in the state register for one cycle.
  // Reset gates and strobes answer at the next edge from their own registers.
  // Clock A answers one edge later, since it picks between its channel and the
  // mask level in a register of its own; clock B is its complement in the same
  // register, so the two phases can never overlap on the sensor.

  // All state of the core outside the edge channels lives in one register
  typedef struct packed {
    logic [`CCDH_POS_W-1:0] pos;
    logic [PIX_W-1:0] pix;
    logic [`CCDH_WIN_IDX_W-1:0] win;
    logic blank;
    logic clk_a;
    logic clk_b;
    logic ref_stb;
    logic data_stb;
    ccdh_drive_s drive;
  } ccdh_core_st_s;

  // Registered state and its next value
  ccdh_core_st_s st_r;
  ccdh_core_st_s st_nxt;
  logic [`CCDH_CHANNELS-1:0] chan_out;

  // Window match flags, one per window, and the pick of the current one
  logic [`CCDH_WINDOWS-1:0] start_hit;
  logic [`CCDH_WINDOWS-1:0] stop_hit;
  logic win_live;
  logic win_start_hit;
  logic win_stop_hit;

  // Grid markers and next-value helpers
  logic pos_wrap;
  logic pix_boundary;
  logic ref_hit;
  logic data_hit;
  logic clk_a_src;

  // One edge generator per programmable channel
  generate
    for (genvar ch = 0; ch < `CCDH_CHANNELS; ch++)
    begin : g_chan
      ccdh_edge_chan u_chan (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pos(st_r.pos),
        .cfg(edge_cfg[ch]),
        .level_out(chan_out[ch])
      );
    end
  endgenerate

  // Grid markers shared by the counters and the window checks
  assign pos_wrap = (st_r.pos == `CCDH_LAST_POS);
  assign pix_boundary = (st_r.pos == `CCDH_FIRST_POS);

  // Every window's toggles meet the pixel count at once; only the
  // low PIX_W bits of a toggle take part, so PIX_W may not exceed 12
  generate
    for (genvar w = 0; w < `CCDH_WINDOWS; w++)
    begin : g_win
      assign start_hit[w] = (st_r.pix == blank_win[w].start[PIX_W-1:0]);
      assign stop_hit[w] = (st_r.pix == blank_win[w].stop[PIX_W-1:0]);
    end
  endgenerate

  // Only the window in turn may toggle; index 3 means all are spent
  always_comb
  begin
    win_live = (st_r.win != `CCDH_WIN_DONE);
    win_start_hit = 1'b0;
    win_stop_hit = 1'b0;
    if (win_live)
    begin
      win_start_hit = start_hit[st_r.win];
      win_stop_hit = stop_hit[st_r.win];
    end
  end

  // Strobes decode the position held now, so they answer one edge later
  assign ref_hit = ccdh_code_hits(ref_sample_loc, st_r.pos);
  assign data_hit = ccdh_code_hits(data_sample_loc, st_r.pos);

  // During blanking the mask level stands in for the clock A channel
  assign clk_a_src = st_r.blank ? blank_mask_level : chan_out[`CCDH_CH_CLKA];

  // Grid counter, pixel counter, blanking sequencer and output shaping
  always_comb
  begin
    st_nxt = st_r;
    // Each sys_clk cycle is one edge position; 48 make a pixel
    if (pos_wrap)
    begin
      st_nxt.pos = `CCDH_FIRST_POS;
      st_nxt.pix = st_r.pix + 1'b1;
    end
    else
      st_nxt.pos = st_r.pos + 1'b1;

    // Windows are checked only at a pixel boundary, so one window at a time;
    // a start and its own stop can never act in the same pixel
    if (pix_boundary)
    begin
      if (!st_r.blank && win_live && win_start_hit)
        st_nxt.blank = 1'b1;
      else if (st_r.blank && win_stop_hit)
      begin
        st_nxt.blank = 1'b0;
        // Advance to the next window; unordered toggles simply never match
        st_nxt.win = st_r.win + 1'b1;
      end
    end

    // A new line restarts the grid and rearms window 0, over whatever the sequencer chose
    if (line_start)
    begin
      st_nxt.pos = `CCDH_FIRST_POS;
      st_nxt.pix = '0;
      st_nxt.win = '0;
      st_nxt.blank = 1'b0;
    end

    // B is the complement of the same next value, so the phases flip on one edge
    st_nxt.clk_a = clk_a_src;
    st_nxt.clk_b = ~st_nxt.clk_a;

    // Strobes and drive codes are only registered on the way out
    st_nxt.ref_stb = ref_hit;
    st_nxt.data_stb = data_hit;
    st_nxt.drive = drive_cfg;
  end

  // Reset parks the window index at spent, so nothing blanks before the first line start
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.win <= `CCDH_WIN_DONE;
      st_r.clk_b <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Sensor clocks; the last-clock driver pin carries clock A
  assign horiz_clock_a = st_r.clk_a;
  assign horiz_clock_b = st_r.clk_b;
  assign last_horiz_clock = st_r.clk_a;

  // Reset gates leave their channel registers directly, an edge ahead of clock A
  assign reset_gate_one = chan_out[`CCDH_CH_RG1];
  assign reset_gate_two = chan_out[`CCDH_CH_RG2];

  // Sampling strobes, one cycle each
  assign ref_level_strobe = st_r.ref_stb;
  assign data_level_strobe = st_r.data_stb;

  // Status and held drive codes
  assign horiz_blanking = st_r.blank;
  assign edge_position = st_r.pos;
  assign drive_code = st_r.drive;

endmodule

`default_nettype wire

//--- verification/ccd_horizontal_edge_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccdh_defines.svh"
module ccd_horizontal_edge_timing_test
  import ccdh_pkg::*;
;
  logic sys_clk = 0, sys_rst = 1, line_start = 0, blank_mask_level = 0, mblank, on = 0;
  ccdh_edge_cfg_s [2:0] edge_cfg = '0;
  logic [5:0] ref_sample_loc = '0, data_sample_loc = '0, edge_position;
  ccdh_drive_s drive_cfg = '0, drive_code;
  ccdh_win_s [2:0] blank_win = '0;
  logic horiz_clock_a, horiz_clock_b, last_horiz_clock, reset_gate_one, reset_gate_two;
  logic ref_level_strobe, data_level_strobe, horiz_blanking, sensor_fault;
  int err_total = 0, cmp_count = 0, mpos, mpix, mwin, ppos, i, n, s, c, mexa;
  int mlev[3], mknown[3];
  always #2.5 sys_clk = ~sys_clk;
  ccdh_timing_core ccdh_timing_core_inst (.sys_clk, .sys_rst, .line_start, .edge_cfg, .ref_sample_loc,
    .data_sample_loc, .drive_cfg, .blank_win, .blank_mask_level, .horiz_clock_a, .horiz_clock_b,
    .last_horiz_clock, .reset_gate_one, .reset_gate_two, .ref_level_strobe, .data_level_strobe,
    .horiz_blanking, .edge_position, .drive_code);
  ccdh_sensor ccdh_sensor_inst (.sys_clk, .sys_rst, .horiz_clock_a, .horiz_clock_b, .sensor_fault);
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int qpos(input logic [5:0] c);
    return (c[3:0] > 4'hb) ? 99 : c[5:4] * 12 + c[3:0];
  endfunction
  // Reference model of position, strobes and windows, checked every cycle
  always @(negedge sys_clk)
    if (on)
    begin
      check(10'(edge_position), 10'(mpos));
      check(10'(horiz_blanking), 10'(mblank));
      check(10'(ref_level_strobe), 10'(qpos(ref_sample_loc) == ppos));
      check(10'(data_level_strobe), 10'(qpos(data_sample_loc) == ppos));
      check(10'(drive_code), 10'(drive_cfg));
      // Channel model: the last edge acted on the previous position; rise wins a tie
      for (c = 0; c < 3; c++)
        if (qpos(edge_cfg[c].rise) == ppos)
          {mknown[c], mlev[c]} = {32'd1, 32'd1};
        else if (qpos(edge_cfg[c].fall) == ppos)
          {mknown[c], mlev[c]} = {32'd1, 32'd0};
      if (mknown[1])
        check(10'(reset_gate_one), 10'(mlev[1] ^ edge_cfg[1].pol));
      if (mknown[2])
        check(10'(reset_gate_two), 10'(mlev[2] ^ edge_cfg[2].pol));
      if (mexa >= 0)
        check({horiz_clock_a, horiz_clock_b, last_horiz_clock}, 10'({mexa[0], !mexa[0], mexa[0]}));
      // Clock A one edge on: mask level while blanking, else the clock A channel
      mexa = mblank ? blank_mask_level : (mknown[0] ? mlev[0] ^ edge_cfg[0].pol : -1);
      if (mpos == 0 && mwin < 3)
        if (!mblank && mpix == blank_win[mwin].start)
          mblank = 1;
        else if (mblank && mpix == blank_win[mwin].stop)
          {mblank, mwin} = {1'b0, mwin + 1};
      ppos = mpos;
      mpos = (mpos + 1) % 48;
      mpix = mpix + (mpos == 0);
    end
  initial
  begin
    void'($urandom(32'h1697144c));
    repeat (3) @(negedge sys_clk);
    check({horiz_clock_a, horiz_clock_b, horiz_blanking, ref_level_strobe}, 10'h4);
    @(posedge sys_clk);
    sys_rst <= 0;
    for (n = 0; n < 6; n++)
    begin
      @(posedge sys_clk);
      on = 0;
      edge_cfg <= 39'({$urandom, $urandom});
      ref_sample_loc <= 6'($urandom);
      data_sample_loc <= 6'($urandom);
      drive_cfg <= 10'($urandom);
      blank_mask_level <= n[0];
      // Toggles strictly increasing; last line breaks the order on purpose
      for (i = 0; i < 3; i++)
      begin
        s = i * 4 + 1 + $urandom % 2;
        blank_win[i] <= '{(n == 5 && i == 1) ? 12'h0 : 12'(s), 12'(s + 1 + $urandom % 2)};
      end
      repeat (3) @(posedge sys_clk);
      line_start <= 1;
      @(posedge sys_clk);
      line_start <= 0;
      @(negedge sys_clk);
      for (i = 0; i < 9 && edge_position !== 6'h00; i++)
        @(negedge sys_clk);
      if (i == 9)
      begin
        err_total++;
        results();
      end
      @(posedge sys_clk);
      mknown = '{0, 0, 0};
      mexa = -1;
      {mpos, ppos, mpix, mwin, mblank, on} = {32'd1, 32'd0, 32'd0, 32'd0, 1'b0, 1'b1};
      repeat (14 * 48) @(posedge sys_clk);
      $display("line %0d done", n);
    end
    check(10'(sensor_fault), 10'h0);
    results();
  end
endmodule
`default_nettype wire

//--- verification/ccdh_sensor.sv
`timescale 1ns/1ps
`default_nettype none
module ccdh_sensor
(
  // Clock
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Transfer gate phases
  input wire logic horiz_clock_a,
  input wire logic horiz_clock_b,
  output logic sensor_fault
);
  // Equal phases would stall charge transfer; latch it for the bench
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      sensor_fault <= 1'b0;
    else if (horiz_clock_a == horiz_clock_b)
      sensor_fault <= 1'b1;
endmodule
`default_nettype wire

//--- verification/ccdh_timing_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccdh_defines.svh"
module ccdh_timing_core_sva
  import ccdh_pkg::*;
(
  // Clock and settings
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic line_start,
  input var ccdh_edge_cfg_s [`CCDH_CHANNELS-1:0] edge_cfg,
  input wire logic [`CCDH_CODE_W-1:0] ref_sample_loc,
  input wire logic [`CCDH_CODE_W-1:0] data_sample_loc,
  input var ccdh_drive_s drive_cfg,
  input wire logic blank_mask_level,
  // Outputs watched
  input wire logic horiz_clock_a,
  input wire logic horiz_clock_b,
  input wire logic last_horiz_clock,
  input wire logic reset_gate_one,
  input wire logic ref_level_strobe,
  input wire logic data_level_strobe,
  input wire logic horiz_blanking,
  input wire logic [`CCDH_POS_W-1:0] edge_position,
  input var ccdh_drive_s drive_code
);
  logic [1:0] run_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Quadrant decode; 7'h7f names no position
  function automatic logic [6:0] qp(input logic [5:0] c);
    qp = (c[3:0] > 4'hb) ? 7'h7f : 7'(c[5:4]) * 7'h0c + 7'(c[3:0]);
  endfunction
  // Past values are only meaningful two edges after reset
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      run_r <= 2'h0;
    else
      run_r <= {run_r[0], 1'b1};
  a_clock_b_inverse: assert property (horiz_clock_b == ~horiz_clock_a) else $error("clock b");
  a_last_follows_a: assert property (last_horiz_clock == horiz_clock_a) else $error("last clock");
  a_position_range: assert property (edge_position <= 6'h2f) else $error("position range");
  a_position_steps: assert property (run_r[0] && edge_position != 6'h2f && !line_start |=>
    edge_position == $past(edge_position) + 6'h1) else $error("position step");
  a_ref_strobe_at: assert property (run_r[1] |-> ref_level_strobe ==
    ({1'b0, $past(edge_position)} == qp($past(ref_sample_loc)))) else $error("ref strobe");
  a_data_strobe_at: assert property (run_r[1] |-> data_level_strobe ==
    ({1'b0, $past(edge_position)} == qp($past(data_sample_loc)))) else $error("data strobe");
  a_gate_rise_pol: assert property (run_r[1] && {1'b0, $past(edge_position)} == qp($past(edge_cfg[1].rise))
    |-> reset_gate_one == ~$past(edge_cfg[1].pol)) else $error("gate rise");
  a_gate_fall_pol: assert property (run_r[1] && {1'b0, $past(edge_position)} == qp($past(edge_cfg[1].fall))
    && {1'b0, $past(edge_position)} != qp($past(edge_cfg[1].rise)) |-> reset_gate_one == $past(edge_cfg[1].pol))
    else $error("gate fall");
  a_blank_mask: assert property (run_r[1] && $past(horiz_blanking) |->
    horiz_clock_a == $past(blank_mask_level)) else $error("blank mask");
  a_drive_held: assert property (run_r[0] |-> drive_code == $past(drive_cfg)) else $error("drive");
endmodule
bind ccdh_timing_core ccdh_timing_core_sva ccdh_timing_core_sva_inst (.sys_clk, .sys_rst, .line_start,
  .edge_cfg, .ref_sample_loc, .data_sample_loc, .drive_cfg, .blank_mask_level, .horiz_clock_a,
  .horiz_clock_b, .last_horiz_clock, .reset_gate_one, .ref_level_strobe, .data_level_strobe,
  .horiz_blanking, .edge_position, .drive_code);
`default_nettype wire
